/* File: core/dfs_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module dfs_edge (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic level_in,
    output logic rise
);
    logic prev_ff;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level_in;
        end
    end

    assign rise = level_in & ~prev_ff;
endmodule
`default_nettype wire

/* File: core/dfs_pkg.sv */
package dfs_pkg;
    localparam int CNT_W = 14;
    localparam int CONV_W = 6;
    localparam logic [13:0] CNT_ZERO = 14'h0000;
    localparam logic [13:0] CNT_ONE = 14'h0001;
    localparam logic [13:0] SETTLE_MAX = 14'h3FFF;
    localparam logic [5:0] CONV_LAST = 6'h3F;
    localparam logic [6:0] RDY_EXTRA = 7'h40;
    localparam logic [6:0] RDY_ZERO = 7'h00;
    localparam logic [6:0] RDY_ONE = 7'h01;
    localparam int SETTLE_CYCLES = 8192;
    localparam int CONV_CYCLES = 64;
    localparam real MCLK_MIN_KHZ = 300.0;
    localparam real MCLK_MAX_KHZ = 15000.0;

    typedef struct packed {
        logic sync;
        logic reset;
        logic cal;
        logic frame_start;
    } dfs_ctrl_type;

    typedef struct packed {
        logic serial_result_valid;
        logic parallel_ready_n;
        logic output_load;
        logic filter_run;
    } dfs_stat_type;
endpackage

/* File: core/dfs_sequencer.sv */
// Overview of operation
// RULE1 - Fourteen bit cycle counter tracks filter position
// RULE2 - Low six bits divide by 64
// RULE3 - Top bit times 8192 cycle settling
// RULE4 - Counter advances each rising clock edge
// RULE5 - Top bit gates first valid indication
// RULE6 - Sync rising edge clears cycle counter
// RULE7 - Filter held until sync sampled low
// RULE8 - Sync leaves calibration values untouched
// RULE9 - Host may pulse sync one cycle
// RULE10 - Serial valid low 8192 cycles after sync
// RULE11 - Parallel ready waits further 64 cycles
// RULE12 - Rates scale with master clock frequency
// RULE13 - Serial valid low when data may be invalid
// RULE14 - Reset acts like sync, clears calibration
// RULE15 - Valid stays set, output refreshes per 64
`timescale 1ns/1ps
`default_nettype none
module dfs_sequencer #(
    parameter int SETTLE = dfs_pkg::SETTLE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire dfs_pkg::dfs_ctrl_type ctrl,
    input wire logic fault,
    output logic serial_result_valid,
    output logic parallel_ready_n,
    output logic output_load,
    output logic filter_run,
    output logic cal_clear,
    output logic [13:0] cycle_count
);
    typedef enum logic [1:0] {
        DFS_HOLD,
        DFS_SETTLE,
        DFS_WAIT_LOAD,
        DFS_RUN
    } dfs_state_type;

    dfs_state_type state_ff;
    logic [13:0] cnt_ff;
    logic settled_ff;
    logic [6:0] rdy_cnt_ff;
    logic valid_ff;
    logic ready_n_ff;
    logic load_ff;
    logic run_ff;
    logic cal_clear_ff;
    logic sync_rise;
    logic reset_rise;
    logic frame_rise;
    logic restart;
    logic hold_req;
    logic conv_end;

    dfs_edge u_sync_edge (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .level_in(ctrl.sync),
        .rise(sync_rise)
    );

    dfs_edge u_reset_edge (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .level_in(ctrl.reset),
        .rise(reset_rise)
    );

    dfs_edge u_frame_edge (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .level_in(ctrl.frame_start),
        .rise(frame_rise)
    );

    // Restart events; reset behaves as sync RULE14
    assign restart = sync_rise | reset_rise | ctrl.cal | frame_rise;
    // Held while sync or reset still high RULE7
    assign hold_req = ctrl.sync | ctrl.reset;
    assign conv_end = cnt_ff[dfs_pkg::CONV_W-1:0] == dfs_pkg::CONV_LAST; // RULE2

    // Counter advances on every edge while running RULE4
    // Fault restarts the settling count from zero
    always_ff @(posedge sys_clk) begin
        if (!rstn || restart || hold_req || fault) begin
            cnt_ff <= dfs_pkg::CNT_ZERO; // RULE6
        end else begin
            cnt_ff <= cnt_ff + dfs_pkg::CNT_ONE; // RULE1
        end
    end

    // Settle latch set once count reaches SETTLE - 1 RULE3
    always_ff @(posedge sys_clk) begin
        if (!rstn || restart || hold_req || fault) begin
            settled_ff <= 1'b0;
        end else if (cnt_ff == 14'(SETTLE - 1)) begin
            settled_ff <= 1'b1; // RULE5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn || restart || hold_req) begin
            state_ff <= DFS_HOLD;
        end else begin
            unique case (state_ff)
                DFS_HOLD: begin
                    state_ff <= DFS_SETTLE; // RULE7
                end
                DFS_SETTLE: begin
                    if (cnt_ff == 14'(SETTLE - 1)) begin
                        state_ff <= DFS_WAIT_LOAD; // RULE10
                    end
                end
                DFS_WAIT_LOAD: begin
                    if (fault) begin
                        state_ff <= DFS_SETTLE; // RULE13
                    end else if (rdy_cnt_ff == dfs_pkg::RDY_ONE) begin
                        state_ff <= DFS_RUN; // RULE11
                    end
                end
                DFS_RUN: begin
                    if (fault) begin
                        state_ff <= DFS_SETTLE;
                    end
                end
            endcase
        end
    end

    // Extra 64 cycles before parallel ready RULE11
    always_ff @(posedge sys_clk) begin
        if (!rstn || state_ff != DFS_WAIT_LOAD) begin
            rdy_cnt_ff <= dfs_pkg::RDY_EXTRA;
        end else if (rdy_cnt_ff != dfs_pkg::RDY_ZERO) begin
            rdy_cnt_ff <= rdy_cnt_ff - dfs_pkg::RDY_ONE;
        end
    end

    // Serial valid low until settled, high after RULE13
    always_ff @(posedge sys_clk) begin
        if (!rstn || restart || hold_req || fault) begin
            valid_ff <= 1'b0; // RULE10
        end else if (settled_ff || cnt_ff == 14'(SETTLE - 1)) begin
            valid_ff <= 1'b1; // RULE15
        end
    end

    // Fault keeps ready inactive until settled again plus 64 cycles, or for 64 cycles only if it hits count SETTLE - 1 in DFS_SETTLE
    always_ff @(posedge sys_clk) begin
        if (!rstn || restart || hold_req || fault) begin
            ready_n_ff <= 1'b1;
        end else if (state_ff == DFS_WAIT_LOAD
                     && rdy_cnt_ff == dfs_pkg::RDY_ONE) begin
            ready_n_ff <= 1'b0; // RULE11
        end
    end

    // Output register refresh once per convolution RULE15
    always_ff @(posedge sys_clk) begin
        if (!rstn || hold_req) begin
            load_ff <= 1'b0;
        end else begin
            load_ff <= conv_end && state_ff != DFS_HOLD; // RULE2
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            run_ff <= 1'b0;
        end else begin
            run_ff <= !hold_req; // RULE7
        end
    end

    // Calibration cleared only by reset, not sync RULE8
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cal_clear_ff <= 1'b1;
        end else begin
            cal_clear_ff <= reset_rise; // RULE14
        end
    end

    // Timing is counted in master clock cycles only RULE12
    assign serial_result_valid = valid_ff;
    assign parallel_ready_n = ready_n_ff;
    assign output_load = load_ff;
    assign filter_run = run_ff;
    assign cal_clear = cal_clear_ff;
    assign cycle_count = cnt_ff;
endmodule
`default_nettype wire

/* File: verif/dfs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dfs_checker #(parameter int SETTLE = 8192) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire dfs_pkg::dfs_ctrl_type ctrl,
    input wire logic fault,
    input wire logic serial_result_valid,
    input wire logic parallel_ready_n,
    input wire logic output_load,
    input wire logic filter_run,
    input wire logic cal_clear,
    input wire logic [13:0] cycle_count
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_sync_hold: assert property (
        ctrl.sync |=> !filter_run && cycle_count == 14'h0000)
        else $error("sync hold");
    a_sync_rel: assert property (
        $fell(ctrl.sync) && ctrl == '0 && !fault |=> filter_run)
        else $error("sync release");
    a_count_step: assert property (
        filter_run && ctrl == '0 && $stable(ctrl) && !fault && !$past(fault)
        && cycle_count != 14'h3FFF |=> cycle_count == $past(cycle_count) + 1)
        else $error("count step");
    a_load_phase: assert property (
        output_load |-> cycle_count[5:0] == 6'h00)
        else $error("load phase");
    a_valid_rise: assert property (
        $rose(serial_result_valid) |-> $past(cycle_count) == 14'(SETTLE - 1))
        else $error("valid rise");
    a_ready_lag: assert property (
        $fell(parallel_ready_n) |-> $past(serial_result_valid, 64)
        && !$past(serial_result_valid, 65))
        else $error("ready lag");
    a_fault_drop: assert property (
        fault |=> !serial_result_valid)
        else $error("fault drop");
    a_reset_cal: assert property (
        $rose(ctrl.reset) |-> ##[1:2] cal_clear)
        else $error("reset cal");
    cover property ($rose(serial_result_valid));
    cover property ($fell(parallel_ready_n));
    cover property (output_load);
endmodule
bind dfs_sequencer dfs_checker #(.SETTLE(SETTLE)) dfs_checker_i (
    .sys_clk(sys_clk), .rstn(rstn), .ctrl(ctrl), .fault(fault),
    .serial_result_valid(serial_result_valid),
    .parallel_ready_n(parallel_ready_n), .output_load(output_load),
    .filter_run(filter_run), .cal_clear(cal_clear),
    .cycle_count(cycle_count));
`default_nettype wire

/* File: verif/dfs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dfs_host_model (
    input wire logic sys_clk,
    output var dfs_pkg::dfs_ctrl_type ctrl
);
    initial ctrl = '0;
    // Falling-edge launch keeps the level settled at rising edges
    task automatic pulse(input int i, input int w);
        @(negedge sys_clk);
        ctrl[i] = 1'b1;
        repeat (w) @(negedge sys_clk);
        ctrl[i] = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int SET = 128;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic fault = 1'b0;
    dfs_pkg::dfs_ctrl_type ctrl;
    logic v, rn, ld, run, cc;
    logic [13:0] cnt;
    int n_errors = 0;
    int check_count = 0;
    always #12.5 sys_clk = ~sys_clk;
    dfs_host_model dfs_host_model_i (.sys_clk(sys_clk), .ctrl(ctrl));
    dfs_sequencer #(.SETTLE(SET)) dfs_sequencer_i (.sys_clk(sys_clk),
        .rstn(rstn), .ctrl(ctrl), .fault(fault), .serial_result_valid(v),
        .parallel_ready_n(rn), .output_load(ld), .filter_run(run),
        .cal_clear(cc), .cycle_count(cnt));
    task automatic check(string s, logic [15:0] a, logic [15:0] e);
        check_count++;
        if (a !== e) begin
            n_errors++;
            $display("BAD %s exp %0d seen %0d", s, e, a);
        end
    endtask
    // Edges until valid, ready or load shows; negative e skips compare unless n hits 999
    task automatic span(string s, int i, int e);
        int n = 0;
        while ((i == 0 ? v : i == 1 ? !rn : ld) !== 1'b1 && n < 999) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (e >= 0 || n == 999) check(s, 16'(n), 16'(e));
    endtask
    task automatic t_sync;
        dfs_host_model_i.pulse(3, 1);
        span("settle", 0, SET);
        check("count", 16'(cnt), 16'(SET));
        span("ready", 1, 64);
        span("load", 2, -1);
        @(posedge sys_clk);
        #1;
        span("load gap", 2, 63);
        check("valid", 16'(v), 16'h0001);
        $display("t_sync done");
    endtask
    task automatic t_hold;
        dfs_host_model_i.pulse(3, 5);
        check("held", {cc, run, cnt}, 16'h0000);
        span("release", 0, SET);
        $display("t_hold done");
    endtask
    task automatic t_restart;
        for (int i = 0; i < 4; i++) begin
            dfs_host_model_i.pulse(i, 1);
            check("cal clear", 16'(cc), 16'(i == 2));
            @(posedge sys_clk);
            #1;
            check("dropped", 16'(v), 16'h0000);
            span("resettle", 0, SET - 1);
        end
        $display("t_restart done");
    endtask
    task automatic t_fault;
        @(posedge sys_clk);
        fault <= 1'b1;
        @(posedge sys_clk);
        fault <= 1'b0;
        #1;
        check("fault", 16'(v), 16'h0000);
        span("refault", 0, SET);
        $display("t_fault done");
    endtask
    task automatic t_rstn;
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("rst hold", {cc, run, cnt}, 16'h8000);
        check("rst flags", 16'({v, rn, ld}), 16'h0002);
        @(posedge sys_clk);
        rstn <= 1'b1;
        span("rst settle", 0, SET);
        $display("t_rstn done");
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        t_sync();
        t_hold();
        t_restart();
        t_fault();
        t_rstn();
        summarize();
    end
    initial begin
        #100us;
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
